//--- pkg/parallel_io_pkg.sv
// Constants and register map for the parallel port block
package parallel_io_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int PORT_WIDTH = 16;
  localparam int ADDR_WIDTH = 4;

  // ----------------------------------------
  // Register byte offsets on the Wishbone slave
  // ----------------------------------------
  localparam logic [ADDR_WIDTH-1:0] OFS_DIRECTION = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] OFS_VALUE = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] OFS_LATCH = 4'h8;
  localparam logic [ADDR_WIDTH-1:0] OFS_ANALOG = 4'hC;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 16'hFFFF;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] ANALOG_RESET = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] ALL_ZERO = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------
  // Bus answer state
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage : parallel_io_pkg

//--- core/parallel_io_port.sv
// Parallel I/O port: direction, latch, pin readback, peripheral output mux
module parallel_io_port
  import parallel_io_pkg::*;
#(
  parameter logic [PORT_WIDTH-1:0] IMPL_MASK = 16'hFFFF
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PORT_WIDTH-1:0] pad_in,
  output logic [PORT_WIDTH-1:0] pad_out,
  output logic [PORT_WIDTH-1:0] pad_oe_n,
  input wire logic [PORT_WIDTH-1:0] periph_drive,
  input wire logic [PORT_WIDTH-1:0] periph_out,
  output logic [PORT_WIDTH-1:0] analog_input_pins
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [PORT_WIDTH-1:0] pin_direction_reg_ff;
  logic [PORT_WIDTH-1:0] output_latch_reg_ff;
  logic [PORT_WIDTH-1:0] analog_pin_select_reg_ff;
  logic [PORT_WIDTH-1:0] pin_sample_ff;
  logic [31:0] read_data_ff;
  bus_state_t bus_state_ff;
  bus_state_t nxt_bus_state;

  // ----------------------------------------
  // Decode wires
  // ----------------------------------------
  logic bus_idle;
  logic bus_request;
  logic bus_write;
  logic hit_direction;
  logic hit_value;
  logic hit_latch;
  logic hit_analog;
  logic write_direction;
  logic write_latch;
  logic write_analog;

  // ----------------------------------------
  // Datapath wires
  // ----------------------------------------
  logic [PORT_WIDTH-1:0] nxt_direction;
  logic [PORT_WIDTH-1:0] nxt_latch;
  logic [PORT_WIDTH-1:0] nxt_analog;
  logic [PORT_WIDTH-1:0] nxt_sample;
  logic [31:0] nxt_read_data;
  logic [PORT_WIDTH-1:0] direction_view;
  logic [PORT_WIDTH-1:0] value_view;
  logic [PORT_WIDTH-1:0] latch_view;
  logic [PORT_WIDTH-1:0] analog_view;
  logic [PORT_WIDTH-1:0] port_drive;
  logic [PORT_WIDTH-1:0] owner_periph;
  logic [PORT_WIDTH-1:0] drive_on;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Upper byte lanes carry nothing: the registers live in the low half
  function automatic logic [PORT_WIDTH-1:0] lane_mask_of(
    input logic [3:0] sel,
    input logic [PORT_WIDTH-1:0] impl
  );
    lane_mask_of = {{8{sel[1]}}, {8{sel[0]}}} & impl;
  endfunction : lane_mask_of

  function automatic logic [PORT_WIDTH-1:0] merge_lanes(
    input logic [PORT_WIDTH-1:0] old_val,
    input logic [31:0] wr_data,
    input logic [3:0] sel,
    input logic [PORT_WIDTH-1:0] impl
  );
    logic [PORT_WIDTH-1:0] lane_mask;
    lane_mask = lane_mask_of(sel, impl);
    merge_lanes = (old_val & ~lane_mask) | (wr_data[PORT_WIDTH-1:0] & lane_mask);
  endfunction : merge_lanes

  function automatic logic addr_hit(
    input logic [ADDR_WIDTH-1:0] adr,
    input logic [ADDR_WIDTH-1:0] ofs
  );
    addr_hit = (adr == ofs);
  endfunction : addr_hit

  // Per-bit selector; the first source wins wherever own is set
  function automatic logic [PORT_WIDTH-1:0] pad_select(
    input logic [PORT_WIDTH-1:0] own,
    input logic [PORT_WIDTH-1:0] first_src,
    input logic [PORT_WIDTH-1:0] second_src
  );
    pad_select = (own & first_src) | (~own & second_src);
  endfunction : pad_select

  function automatic logic [31:0] widen(
    input logic [PORT_WIDTH-1:0] half
  );
    widen = {ALL_ZERO, half};
  endfunction : widen

  function automatic logic [31:0] read_select(
    input logic [ADDR_WIDTH-1:0] adr,
    input logic [PORT_WIDTH-1:0] dir_word,
    input logic [PORT_WIDTH-1:0] value_word,
    input logic [PORT_WIDTH-1:0] latch_word,
    input logic [PORT_WIDTH-1:0] analog_word
  );
    case (adr)
      OFS_DIRECTION:
      begin
        read_select = widen(dir_word);
      end
      OFS_VALUE:
      begin
        read_select = widen(value_word);
      end
      OFS_LATCH:
      begin
        read_select = widen(latch_word);
      end
      OFS_ANALOG:
      begin
        read_select = widen(analog_word);
      end
      default:
      begin
        read_select = UNMAPPED_READ;
      end
    endcase
  endfunction : read_select

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign bus_idle = (bus_state_ff == BUS_IDLE);
  assign bus_request = wb_cyc_i & wb_stb_i & bus_idle;
  assign bus_write = bus_request & wb_we_i;
  assign hit_direction = addr_hit(wb_adr_i, OFS_DIRECTION);
  assign hit_value = addr_hit(wb_adr_i, OFS_VALUE);
  assign hit_latch = addr_hit(wb_adr_i, OFS_LATCH);
  assign hit_analog = addr_hit(wb_adr_i, OFS_ANALOG);
  assign write_direction = bus_write & hit_direction;
  // Value register has no storage of its own: its writes land in the latch
  assign write_latch = bus_write & (hit_latch | hit_value);
  assign write_analog = bus_write & hit_analog;

  // ----------------------------------------
  // Direction register
  // ----------------------------------------
  // Unimplemented bits never get set, and the read view also masks them with IMPL_MASK
  assign nxt_direction = write_direction ?
    merge_lanes(pin_direction_reg_ff, wb_dat_i, wb_sel_i, IMPL_MASK) :
    pin_direction_reg_ff;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_direction_reg_ff <= DIRECTION_RESET & IMPL_MASK;
    end
    else
    begin
      pin_direction_reg_ff <= nxt_direction;
    end
  end

  // ----------------------------------------
  // Output latch
  // ----------------------------------------
  assign nxt_latch = write_latch ?
    merge_lanes(output_latch_reg_ff, wb_dat_i, wb_sel_i, IMPL_MASK) :
    output_latch_reg_ff;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      output_latch_reg_ff <= LATCH_RESET;
    end
    else
    begin
      output_latch_reg_ff <= nxt_latch;
    end
  end

  // ----------------------------------------
  // Analog select register
  // ----------------------------------------
  // All pins start digital so nothing is fed to the converter by default
  assign nxt_analog = write_analog ?
    merge_lanes(analog_pin_select_reg_ff, wb_dat_i, wb_sel_i, IMPL_MASK) :
    analog_pin_select_reg_ff;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      analog_pin_select_reg_ff <= ANALOG_RESET;
    end
    else
    begin
      analog_pin_select_reg_ff <= nxt_analog;
    end
  end

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // One stage only: a read lags a pin change by a cycle
  assign nxt_sample = pad_in & IMPL_MASK;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_sample_ff <= ALL_ZERO;
    end
    else
    begin
      pin_sample_ff <= nxt_sample;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Loaded only when a request is taken, so it holds until the next one
  assign nxt_read_data = bus_request ?
    read_select(wb_adr_i, direction_view, value_view, latch_view,
      analog_view) :
    read_data_ff;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      read_data_ff <= UNMAPPED_READ;
    end
    else
    begin
      read_data_ff <= nxt_read_data;
    end
  end

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  // One-cycle ack; a request still held in the ack cycle is not retaken
  always_comb
  begin
    nxt_bus_state = BUS_IDLE;
    case (bus_state_ff)
      BUS_IDLE:
      begin
        if (bus_request)
        begin
          nxt_bus_state = BUS_ACK;
        end
        else
        begin
          nxt_bus_state = BUS_IDLE;
        end
      end
      BUS_ACK:
      begin
        nxt_bus_state = BUS_IDLE;
      end
      default:
      begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_state_ff <= BUS_IDLE;
    end
    else
    begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  assign wb_ack_o = (bus_state_ff == BUS_ACK);
  assign wb_dat_o = read_data_ff;

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  // Analog pins read low so stray voltages never show as digital ones
  assign direction_view = pin_direction_reg_ff & IMPL_MASK;
  assign value_view = pin_sample_ff & ~analog_pin_select_reg_ff;
  assign latch_view = output_latch_reg_ff & IMPL_MASK;
  assign analog_view = analog_pin_select_reg_ff & IMPL_MASK;

  // ----------------------------------------
  // Pad multiplexers
  // ----------------------------------------
  // Peripheral wins both muxes; an input-only peripheral never raises drive
  assign port_drive = ~pin_direction_reg_ff & IMPL_MASK;
  assign owner_periph = periph_drive & IMPL_MASK;
  assign drive_on = pad_select(owner_periph, owner_periph, port_drive);
  assign pad_out = pad_select(owner_periph, periph_out, output_latch_reg_ff);
  assign pad_oe_n = ~drive_on;

  // ----------------------------------------
  // Converter feed
  // ----------------------------------------
  // Converter sees only analog-selected pins; the driven level if left as output
  assign analog_input_pins = pad_in & analog_pin_select_reg_ff & IMPL_MASK;

endmodule : parallel_io_port

//--- test/pin_world_model.sv
// Pin world model: pad level from the port driver or an outside source
module pin_world_model
(
  input logic [15:0] pad_out,
  input logic [15:0] pad_oe_n,
  input logic [15:0] ext_level,
  output logic [15:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pads read back their own level, so converters see it too
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule : pin_world_model

//--- test/parallel_io_checker.sv
// Assertions on bus answers and pad ownership
module parallel_io_checker
(
  input logic sys_clk,
  input logic reset,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic [15:0] pad_in,
  input logic [15:0] pad_out,
  input logic [15:0] pad_oe_n,
  input logic [15:0] periph_drive,
  input logic [15:0] periph_out,
  input logic [15:0] analog_input_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_follows: assert property (taken |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_dat_holds: assert property (!taken |=> $stable(wb_dat_o)) else $error("dat moved");
  a_upper_zero: assert property (wb_ack_o |-> !wb_dat_o[31:16]) else $error("upper");
  a_periph_data: assert property ((pad_out & periph_drive) == (periph_out & periph_drive))
    else $error("pad data");
  a_periph_oe: assert property (!(pad_oe_n & periph_drive)) else $error("pad oe");
  a_analog_gate: assert property (!(analog_input_pins & ~pad_in)) else $error("feed");
  a_reset_inputs: assert property ($fell(reset) |-> &(pad_oe_n | periph_drive))
    else $error("not inputs");
  c_write: cover property (taken && wb_we_i);
  c_read: cover property (taken && !wb_we_i);
  c_periph: cover property (|periph_drive);
endmodule : parallel_io_checker

//--- test/tb_top.sv
// Self-checking bench for the parallel port
module tb_top;
  import parallel_io_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, reset = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [15:0] pad_in, pad_out, pad_oe_n, analog_input_pins;
  logic [15:0] periph_drive = 0, periph_out = 16'h0303, ext_level = 16'hA5C3;
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  parallel_io_port #(.IMPL_MASK(16'h7FFF)) dut_u (.*);
  pin_world_model pins_u (.*);
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Hang guard, far above the few dozen cycles the tests need
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      n_fail++;
  endtask : chk
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, 4'h3);
    chk(q, exp);
  endtask : rd
  task automatic t_regs();
    rd(OFS_DIRECTION, 32'h7FFF);
    rd(OFS_LATCH, 32'h0);
    rd(OFS_ANALOG, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'h1, OFS_VALUE, 32'hFFFF, 4'h1);
    rd(OFS_LATCH, 32'h00FF);
    bus(1'h1, OFS_LATCH, 32'hFFFF, 4'h3);
    rd(OFS_LATCH, 32'h7FFF);
    $display("regs done");
  endtask : t_regs
  task automatic t_pins();
    bus(1'h1, OFS_LATCH, 32'h5A5A, 4'h3);
    bus(1'h1, OFS_DIRECTION, 32'hFF00, 4'h3);
    @(posedge sys_clk);
    chk(pad_oe_n & 16'h7FFF, 32'h7F00);
    rd(OFS_VALUE, 32'h255A);
    $display("pins done");
  endtask : t_pins
  task automatic t_periph();
    periph_drive <= 16'h0F0F;
    rd(OFS_VALUE, 32'h2353);
    chk(pad_oe_n & 16'h7FFF, 32'h7000);
    chk(pad_out & 16'h7FFF, 32'h5353);
    bus(1'h1, OFS_ANALOG, 32'h00F0, 4'h3);
    rd(OFS_VALUE, 32'h2303);
    chk(analog_input_pins, 32'h0050);
    $display("periph done");
  endtask : t_periph
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'h0;
    t_regs();
    t_pins();
    t_periph();
    end_sim();
  end
endmodule : tb_top
bind parallel_io_port parallel_io_checker chk_u (.*);
